// ==== hdl/prhg_cfg.svh ====
// register map, field positions and timing counts of the health-gated random source
`ifndef PRHG_CFG_SVH
`define PRHG_CFG_SVH
`define PRHG_ADDR_CTRL      4'h0
`define PRHG_ADDR_STATUS    4'h1
`define PRHG_ADDR_DATA      4'h2
`define PRHG_ADDR_IRQ_STAT  4'h3
`define PRHG_ADDR_IRQ_MASK  4'h4
`define PRHG_ADDR_ID        4'h5
`define PRHG_CTRL_EN        0
`define PRHG_CTRL_CONT      1
`define PRHG_CTRL_SELFTEST  2
`define PRHG_ST_VALID       0
`define PRHG_ST_TOTFAIL     1
`define PRHG_ST_DEFECT      2
`define PRHG_ST_STARTED     3
`define PRHG_ST_STBUSY      4
`define PRHG_ST_STPASS      5
`define PRHG_ST_STDONE      6
`define PRHG_IRQ_READY      0
`define PRHG_IRQ_FAIL       1
`define PRHG_IRQ_STDONE     2
`define PRHG_CTRL_RESET     8'h00
`define PRHG_RUN_LIMIT      8'h20
`define PRHG_WIN_LEN        12'h100
`define PRHG_ONES_LO        12'h60
`define PRHG_ONES_HI        12'ha0
`define PRHG_PERIOD_LEN     16'h1000
`define PRHG_ST_LEN         12'h080
`endif

// ==== hdl/prhg_pkg.sv ====
// types of the health-gated random source
package prhg_pkg;
	typedef enum logic [1:0] {PRHG_IDLE, PRHG_STARTUP, PRHG_RUN, PRHG_BLOCKED} prhg_state_type;
endpackage

// ==== hdl/prhg_total_fail.sv ====
// total failure detector: stuck raw bit run length
`timescale 1ns/1ns
`include "prhg_cfg.svh"
module prhg_total_fail #(
	parameter int RUN_W = 8
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	input  wire logic clr_i,
	input  wire logic bit_vld_i,
	input  wire logic bit_i,
	output logic      fail_o
);
	if (RUN_W < 6) begin : g_run_w_check
		$error("run counter too narrow for the run limit");
	end
	logic [RUN_W-1:0] run_q;
	logic             last_q;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || clr_i) begin
			run_q  <= '0;
			last_q <= 1'b0;
		end else if (bit_vld_i) begin
			last_q <= bit_i;
			run_q  <= (bit_i == last_q) ? run_q + 1'b1 : '0;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || clr_i) begin
			fail_o <= 1'b0;
		end else if (bit_vld_i && run_q >= RUN_W'(`PRHG_RUN_LIMIT)) begin
			fail_o <= 1'b1;
		end
	end
endmodule // prhg_total_fail

// ==== hdl/prhg_online_test.sv ====
// online statistical test: ones count per window
`timescale 1ns/1ns
`include "prhg_cfg.svh"
module prhg_online_test #(
	parameter int CNT_W = 12
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	input  wire logic clr_i,
	input  wire logic run_i,
	input  wire logic bit_vld_i,
	input  wire logic bit_i,
	output logic      done_o,
	output logic      defect_o
);
	if (CNT_W < 9) begin : g_cnt_w_check
		$error("window counter too narrow");
	end
	logic [CNT_W-1:0] pos_q;
	logic [CNT_W-1:0] ones_q;
	logic             last;
	logic [CNT_W-1:0] ones_n;
	assign last   = (pos_q == CNT_W'(`PRHG_WIN_LEN) - 1'b1);
	assign ones_n = ones_q + CNT_W'(bit_i);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || clr_i || !run_i) begin
			pos_q  <= '0;
			ones_q <= '0;
		end else if (bit_vld_i) begin
			pos_q  <= last ? '0 : pos_q + 1'b1;
			ones_q <= last ? '0 : ones_n;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || clr_i) begin
			done_o   <= 1'b0;
			defect_o <= 1'b0;
		end else begin
			done_o <= run_i && bit_vld_i && last;
			if (run_i && bit_vld_i && last &&
			    (ones_n < CNT_W'(`PRHG_ONES_LO) || ones_n > CNT_W'(`PRHG_ONES_HI)))
				defect_o <= 1'b1;
		end
	end
endmodule // prhg_online_test

// ==== hdl/prhg_core.sv ====
// health-gated physical random source with octet register interface
`timescale 1ns/1ns
`include "prhg_cfg.svh"
module prhg_core #(
	parameter logic [7:0] ID_VALUE = 8'h5a  // arbitrary identification value
) (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       raw_vld_i,
	input  wire logic       raw_bit_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	// registers and state
	logic [7:0]              ctrl_q;
	logic [7:0]              mask_q;
	logic [2:0]              istat_q;
	prhg_pkg::prhg_state_type state_q;
	logic [7:0]              shift_q;
	logic [2:0]              nbit_q;
	logic [7:0]              data_q;
	logic                    valid_q;
	logic                    tainted_q;
	logic [15:0]             per_q;
	logic                    st_busy_q;
	logic                    st_pass_q;
	logic                    st_done_q;
	logic [11:0]             st_cnt_q;
	logic                    test_clr;
	logic                    tf_fail;
	logic                    ot_done;
	logic                    ot_defect;
	logic                    ot_run;
	logic                    en;
	logic                    st_fail;
	logic                    st_start;
	logic                    data_rd;
	logic                    stat_rd;
	logic                    byte_end;
	logic                    ok;
	logic                    vld_ok;
	logic [7:0]              status;
	assign en       = ctrl_q[`PRHG_CTRL_EN];
	assign st_start = wr_i && addr_i == `PRHG_ADDR_CTRL && wdata_i[`PRHG_CTRL_SELFTEST];
	assign data_rd  = rd_i && addr_i == `PRHG_ADDR_DATA;
	assign stat_rd  = rd_i && addr_i == `PRHG_ADDR_IRQ_STAT;
	assign test_clr = !en || st_start;
	assign byte_end = raw_vld_i && nbit_q == 3'h7;
	assign ok       = !tf_fail && !ot_defect;
	assign vld_ok   = valid_q && ok;
	////////////////////////////////////////////////////////////////////////////////
	// health tests
	prhg_total_fail #(.RUN_W(8)) prhg_total_fail_inst (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.clr_i     (test_clr),
		.bit_vld_i (raw_vld_i && en),
		.bit_i     (raw_bit_i),
		.fail_o    (tf_fail)
	);
	// continuous runs always; periodic runs one window per period
	assign ot_run = en && (state_q == prhg_pkg::PRHG_STARTUP || ctrl_q[`PRHG_CTRL_CONT] ||
	                       per_q < 16'(`PRHG_WIN_LEN) + 16'h0002);
	prhg_online_test #(.CNT_W(12)) prhg_online_test_inst (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.clr_i     (test_clr),
		.run_i     (ot_run),
		.bit_vld_i (raw_vld_i),
		.bit_i     (raw_bit_i),
		.done_o    (ot_done),
		.defect_o  (ot_defect)
	);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || !en || ctrl_q[`PRHG_CTRL_CONT]) begin
			per_q <= '0;
		end else if (raw_vld_i) begin
			per_q <= (per_q == `PRHG_PERIOD_LEN - 16'h0001) ? '0 : per_q + 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// gating state machine
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_q <= prhg_pkg::PRHG_IDLE;
		end else if (test_clr) begin
			state_q <= en ? prhg_pkg::PRHG_STARTUP : prhg_pkg::PRHG_IDLE;
		end else begin
			unique case (state_q)
				prhg_pkg::PRHG_IDLE: begin
					state_q <= prhg_pkg::PRHG_STARTUP;
				end
				prhg_pkg::PRHG_STARTUP: begin
					if (!ok)
						state_q <= prhg_pkg::PRHG_BLOCKED;
					else if (ot_done)
						state_q <= prhg_pkg::PRHG_RUN;
				end
				prhg_pkg::PRHG_RUN: begin
					if (!ok)
						state_q <= prhg_pkg::PRHG_BLOCKED;
				end
				prhg_pkg::PRHG_BLOCKED: begin
					state_q <= prhg_pkg::PRHG_BLOCKED;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// octet assembly and output gate
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || test_clr) begin
			shift_q <= '0;
			nbit_q  <= '0;
		end else if (raw_vld_i) begin
			shift_q <= {shift_q[6:0], raw_bit_i};
			nbit_q  <= nbit_q + 3'h1;
		end
	end
	// any unhealthy bit poisons the octet being built
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || test_clr) begin
			tainted_q <= 1'b0;
		end else if (byte_end) begin
			tainted_q <= 1'b0;
		end else if (!ok) begin
			tainted_q <= 1'b1;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || test_clr || !ok || state_q != prhg_pkg::PRHG_RUN) begin
			valid_q <= 1'b0;
			data_q  <= '0;
		end else if (byte_end && !tainted_q) begin
			valid_q <= 1'b1;
			data_q  <= {shift_q[6:0], raw_bit_i};
		end else if (data_rd) begin
			valid_q <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// hardware total-failure self-test
	assign st_fail = tf_fail;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			st_busy_q <= 1'b0;
			st_pass_q <= 1'b0;
			st_done_q <= 1'b0;
			st_cnt_q  <= '0;
		end else if (st_start) begin
			st_busy_q <= 1'b1;
			st_pass_q <= 1'b0;
			st_done_q <= 1'b0;
			st_cnt_q  <= '0;
		end else if (st_busy_q) begin
			if (st_fail) begin
				st_busy_q <= 1'b0;
				st_done_q <= 1'b1;
			end else if (raw_vld_i) begin
				st_cnt_q <= st_cnt_q + 12'h001;
				if (st_cnt_q == `PRHG_ST_LEN - 12'h001) begin
					st_busy_q <= 1'b0;
					st_done_q <= 1'b1;
					st_pass_q <= 1'b1;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// control, interrupts and read port
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ctrl_q <= `PRHG_CTRL_RESET;
		end else if (wr_i && addr_i == `PRHG_ADDR_CTRL) begin
			ctrl_q <= {5'h00, 1'b0, wdata_i[`PRHG_CTRL_CONT:`PRHG_CTRL_EN]};
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			mask_q <= '0;
		end else if (wr_i && addr_i == `PRHG_ADDR_IRQ_MASK) begin
			mask_q <= {5'h00, wdata_i[2:0]};
		end
	end
	// set wins over the clear of the read
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			istat_q <= '0;
		end else begin
			istat_q <= (stat_rd ? 3'h0 : istat_q) |
			           {st_busy_q && (st_fail || (raw_vld_i && st_cnt_q == `PRHG_ST_LEN - 12'h001)),
			            state_q != prhg_pkg::PRHG_BLOCKED && en && !ok && !test_clr,
			            state_q == prhg_pkg::PRHG_STARTUP && ok && ot_done && !test_clr};
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(istat_q & mask_q[2:0]);
	end
	assign status = {1'b0, st_done_q, st_pass_q, st_busy_q, state_q == prhg_pkg::PRHG_RUN,
	                 ot_defect, tf_fail, vld_ok};
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || !rd_i) begin
			rdata_o <= '0;
		end else begin
			unique case (addr_i)
				`PRHG_ADDR_CTRL:     rdata_o <= ctrl_q;
				`PRHG_ADDR_STATUS:   rdata_o <= status;
				`PRHG_ADDR_DATA:     rdata_o <= vld_ok ? data_q : 8'h00;
				`PRHG_ADDR_IRQ_STAT: rdata_o <= {5'h00, istat_q};
				`PRHG_ADDR_IRQ_MASK: rdata_o <= mask_q;
				`PRHG_ADDR_ID:       rdata_o <= ID_VALUE;
				default:             rdata_o <= 8'h00;
			endcase
		end
	end
endmodule // prhg_core

// ==== dv/prhg_core_props.sv ====
// port assertions of the health-gated random source
`timescale 1ns/1ns
`include "prhg_cfg.svh"
module prhg_core_props #(
	parameter logic [7:0] ID_VALUE = 8'h5a
) (
	input wire logic       ref_clk_i,
	input wire logic       rst_b_i,
	input wire logic       raw_vld_i,
	input wire logic       raw_bit_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [7:0] mask_q;
	logic [3:0] quiet_q;
	////////////////////////////////
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i)
			mask_q <= 8'h00;
		else if (wr_i && addr_i == `PRHG_ADDR_IRQ_MASK)
			mask_q <= wdata_i;
	end
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || raw_vld_i)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end
	////////////////////////////////
	sequence data_rd_s;
		rd_i && addr_i == `PRHG_ADDR_DATA && !raw_vld_i && quiet_q > 4'h4;
	endsequence
	sequence stat_rd_s;
		rd_i && addr_i == `PRHG_ADDR_STATUS;
	endsequence
	////////////////////////////////
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read answer");
	chk_id_read: assert property (rd_i && addr_i == `PRHG_ADDR_ID |=> rdata_o == ID_VALUE)
		else $error("identification value wrong");
	chk_unmapped_zero: assert property (rd_i && addr_i > 4'h5 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_valid_gated: assert property (stat_rd_s |=> !(rdata_o[0] && rdata_o[2:1] != 2'b00))
		else $error("data valid while a test fails");
	chk_read_clears: assert property (data_rd_s ##1 !raw_vld_i ##1 stat_rd_s |=>
		!rdata_o[0])
		else $error("data valid not cleared by data read");
	chk_selftest_pass: assert property (stat_rd_s |=> !rdata_o[5] || rdata_o[6])
		else $error("self-test pass without done");
	chk_irq_masked: assert property ((mask_q == 8'h00) [*2] |-> !irq_o)
		else $error("interrupt high with all sources masked");
	chk_reset_quiet: assert property ($rose(rst_b_i) |-> !irq_o && rdata_o == 8'h00)
		else $error("outputs not cleared by reset");
endmodule // prhg_core_props

bind prhg_core prhg_core_props #(.ID_VALUE(ID_VALUE)) prhg_core_props_inst (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .raw_vld_i(raw_vld_i), .raw_bit_i(raw_bit_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.irq_o(irq_o));

// ==== dv/test_prhg_core.sv ====
// self-checking bench of the health-gated random source
`timescale 1ns/1ns
`include "prhg_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_prhg_core;
	typedef struct {logic w; logic [3:0] a; logic [7:0] d;} prhg_row_type;
	logic         ref_clk_i   = 1'b0;
	logic         rst_b_i     = 1'b0;
	logic         raw_vld_i   = 1'b0;
	logic         raw_bit_i   = 1'b0;
	logic [3:0]   addr_i      = 4'h0;
	logic [7:0]   wdata_i     = 8'h00;
	logic         wr_i        = 1'b0;
	logic         rd_i        = 1'b0;
	logic [7:0]   rdata_o;
	logic         irq_o;
	logic [7:0]   v;
	int           errors      = 0;
	int           checks_done = 0;
	int           cycles      = 0;
	prhg_row_type rows [12]   = '{
		'{1'b0, 4'h5, 8'h5a}, '{1'b0, 4'h9, 8'h00}, '{1'b1, 4'h9, 8'hff}, '{1'b0, 4'h9, 8'h00},
		'{1'b0, 4'h1, 8'h00}, '{1'b0, 4'h2, 8'h00}, '{1'b0, 4'h3, 8'h00}, '{1'b0, 4'h0, 8'h00},
		'{1'b1, 4'h4, 8'h07}, '{1'b0, 4'h4, 8'h07}, '{1'b1, 4'h0, 8'h03}, '{1'b0, 4'h0, 8'h03}};
	prhg_core prhg_core_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .raw_vld_i(raw_vld_i),
		.raw_bit_i(raw_bit_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .irq_o(irq_o));
	////////////////////////////////
	always #25 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end
	////////////////////////////////
	task automatic final_report();
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		q = rdata_o;
	endtask
	task automatic feed(input logic [7:0] p, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i);
			raw_vld_i <= 1'b1;
			raw_bit_i <= p[7 - i % 8];
		end
		@(posedge ref_clk_i);
		raw_vld_i <= 1'b0;
	endtask
	task automatic restart(input logic [7:0] c);
		wr(`PRHG_ADDR_CTRL, 8'h00);
		wr(`PRHG_ADDR_CTRL, c);
	endtask
	////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			else begin
				rd(rows[i].a, v);
				`CHK(v, rows[i].d)
			end
		end
		// continuous mode: held in start-up, no data until start-up window passes
		feed(8'hca, 248);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h00)
		feed(8'hca, 16);
		@(negedge ref_clk_i);
		`CHK(irq_o, 1'b1)
		rd(`PRHG_ADDR_IRQ_STAT, v);
		`CHK(v, 8'h01)
		rd(`PRHG_ADDR_IRQ_STAT, v);
		`CHK(v, 8'h00)
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h01)
		rd(`PRHG_ADDR_DATA, v);
		`CHK(v, 8'hca)
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h00)
		feed(8'hee, 248);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h04)
		// periodic mode, then stuck source in operation
		restart(8'h01);
		feed(8'hca, 264);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h01)
		feed(8'hee, 256);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h01)
		feed(8'hff, 40);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h02)
		rd(`PRHG_ADDR_IRQ_STAT, v);
		`CHK(v & 8'h02, 8'h02)
		// stuck source right at start
		restart(8'h03);
		feed(8'h00, 40);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h02)
		// biased source
		restart(8'h03);
		feed(8'hee, 264);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h07, 8'h04)
		// self-test pass and fail
		wr(`PRHG_ADDR_CTRL, 8'h05);
		feed(8'hca, 136);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h70, 8'h60)
		wr(`PRHG_ADDR_CTRL, 8'h05);
		feed(8'hff, 40);
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v & 8'h70, 8'h40)
		// masked interrupt, then reset in mid-run
		`CHK(irq_o, 1'b1)
		wr(`PRHG_ADDR_IRQ_MASK, 8'h00);
		repeat (2) @(negedge ref_clk_i);
		`CHK(irq_o, 1'b0)
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		@(negedge ref_clk_i);
		`CHK(irq_o, 1'b0)
		rd(`PRHG_ADDR_STATUS, v);
		`CHK(v, 8'h00)
		rd(`PRHG_ADDR_IRQ_STAT, v);
		`CHK(v, 8'h00)
		final_report();
	end
endmodule // test_prhg_core
